// [core/sras_pkg.sv]
/*
  Package for the SPI register access slave: datagram layout, widths, reset values.
  Assumes a 100 MHz system clock and an SPI master clocking at most a quarter of it.
*/
package sras_pkg;
  localparam int FRAME_BITS   = 40;            // Datagram length
  localparam int DATA_BITS    = 32;            // Data field width
  localparam int ADDR_BITS    = 7;             // Register address width
  localparam int STATUS_BITS  = 8;             // Status byte width
  localparam int WRITE_BIT    = 39;            // Access type bit position
  localparam int ADDR_MSB     = 38;            // Address field top
  localparam int ADDR_LSB     = 32;            // Address field bottom
  localparam int SYNC_STAGES  = 2;             // Synchroniser depth
  localparam int CNT_BITS     = 6;             // Bit counter width
  localparam logic [5:0] CNT_RST   = 6'h00;    // Bit counter after reset
  localparam logic [5:0] CNT_FULL  = 6'h28;    // Forty bits seen
  localparam logic [39:0] SHIFT_RST = 40'h0000000000; // Shift register after reset
  localparam logic [31:0] DATA_RST  = 32'h00000000;   // Reply data after reset
  localparam logic [1:0]  SYNC_RST  = 2'h3;            // Idle level of select; serial clock also reset high

  typedef enum logic [1:0] {
    SRAS_IDLE = 2'b00,
    SRAS_SHIFT = 2'b01,
    SRAS_DONE = 2'b11
  } sras_state_t;
endpackage

// [core/sras_link_if.sv]
/*
  Interface carrying synchronised link events from the pin stage to the core.
  Assumes both ends run on i_clk_sys.
*/
`timescale 1ns/100ps
interface sras_link_if;
  logic sel_fall;   // Select went low
  logic sel_rise;   // Select went high
  logic sel_act;    // Select is low
  logic clk_rise;   // Serial clock rising edge
  logic clk_fall;   // Serial clock falling edge
  logic din;        // Synchronised serial input

  modport src
  (
    output sel_fall, sel_rise, sel_act, clk_rise, clk_fall, din
  );
  modport dst
  (
    input sel_fall, sel_rise, sel_act, clk_rise, clk_fall, din
  );
endinterface

// [core/sras_pin_sync.sv]
/*
  Pin synchroniser for select, serial clock and serial data, edge finder for select and serial clock.
  Assumes the pins are asynchronous to i_clk_sys.
*/
`timescale 1ns/100ps
module sras_pin_sync
  import sras_pkg::*;
(
  input  wire logic i_clk_sys,         // System clock
  input  wire logic i_rst,             // Synchronous reset
  input  wire logic i_host_select_n,   // Chip select pin
  input  wire logic i_host_serial_clock, // Serial clock pin
  input  wire logic i_host_serial_in,  // Serial data pin
  sras_link_if.src  link               // Events to the core
);
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic       sel_prev;
  logic       clk_prev;

  // Two flops per pin, then one delay stage for edge detection
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sel_sync <= SYNC_RST;
      clk_sync <= SYNC_RST;
      din_sync <= 2'h0;
      sel_prev <= 1'b1;
      clk_prev <= 1'b1;
    end
    else
    begin
      sel_sync <= {sel_sync[0], i_host_select_n};
      clk_sync <= {clk_sync[0], i_host_serial_clock};
      din_sync <= {din_sync[0], i_host_serial_in};
      sel_prev <= sel_sync[1];
      clk_prev <= clk_sync[1];
    end
  end

  // Edge events read the second stage and the delay stage
  assign link.sel_fall = sel_prev & ~sel_sync[1];
  assign link.sel_rise = ~sel_prev & sel_sync[1];
  assign link.sel_act  = ~sel_sync[1];
  assign link.clk_rise = ~clk_prev & clk_sync[1];
  assign link.clk_fall = clk_prev & ~clk_sync[1];
  assign link.din      = din_sync[1];
endmodule

// [core/sras_spi_slave.sv]
/*
  SPI register access slave: 40-bit datagrams, pipelined reads, status byte lead-in,
  pass-through daisy chaining beyond 40 bits.
  Assumes a register file that answers o_reg_addr combinationally on i_reg_rdata,
  and a master clocking at most a quarter of i_clk_sys.
*/
`timescale 1ns/100ps
module sras_spi_slave
  import sras_pkg::*;
#(
  parameter int FRAME_W = FRAME_BITS   // Datagram length
)
(
  input  wire logic                      i_clk_sys,           // System clock
  input  wire logic                      i_rst,               // Synchronous reset, active high
  input  wire logic                      i_host_select_n,     // Chip select, active low
  input  wire logic                      i_host_serial_clock, // Serial clock from master
  input  wire logic                      i_host_serial_in,    // Serial data from master
  output logic                           o_host_serial_out,   // Serial data to master
  input  wire logic [STATUS_BITS-1:0]    i_status_events,     // Selected status event bits
  output logic [ADDR_BITS-1:0]           o_reg_addr,          // Register address
  output logic [DATA_BITS-1:0]           o_reg_wdata,         // Write data
  output logic                           o_reg_we,            // Write strobe, one cycle
  output logic                           o_reg_re,            // Read strobe, one cycle
  input  wire logic [DATA_BITS-1:0]      i_reg_rdata          // Read data for o_reg_addr
);
  import sras_pkg::*;

  sras_link_if link ();

  sras_pin_sync u_sync
  (
    .i_clk_sys           (i_clk_sys),
    .i_rst               (i_rst),
    .i_host_select_n     (i_host_select_n),
    .i_host_serial_clock (i_host_serial_clock),
    .i_host_serial_in    (i_host_serial_in),
    .link                (link)
  );

  // Frame state, shift path and reply storage
  sras_state_t          state;          // Frame state
  sras_state_t          next_state;     // Next frame state
  logic [FRAME_W-1:0]   shift;          // Datagram shift register
  logic [FRAME_W-1:0]   next_shift;     // Next shift register value
  logic [CNT_BITS-1:0]  bit_cnt;        // Rising serial clocks in this frame
  logic [CNT_BITS-1:0]  next_bit_cnt;   // Next bit count
  logic [DATA_BITS-1:0] reply_data;     // Data field of the next reply
  logic                 sdo;            // Serial output bit
  logic                 sdo_load;       // First status bit is due

  // Frame events seen in this cycle; serial clock counts only inside a frame
  wire                  frame_start = (state == SRAS_IDLE) && link.sel_fall;
  wire                  in_frame    = (state == SRAS_SHIFT) && link.sel_act;
  wire                  bit_in      = in_frame && link.clk_rise;
  wire                  bit_out     = in_frame && link.clk_fall;
  wire                  frame_end   = (state == SRAS_SHIFT) && link.sel_rise;

  // Datagram field decode
  wire                  frame_ok  = (bit_cnt >= CNT_FULL);
  wire                  cmd_write = shift[WRITE_BIT];
  wire [ADDR_BITS-1:0]  cmd_addr  = shift[ADDR_MSB:ADDR_LSB];
  wire [DATA_BITS-1:0]  cmd_data  = shift[DATA_BITS-1:0];
  wire                  take_cmd  = frame_end && frame_ok;
  wire                  take_wr   = take_cmd && cmd_write;
  wire                  take_rd   = take_cmd && !cmd_write;

  // Frame state sequence
  always_comb
  begin
    next_state = state;
    case (state)
      SRAS_IDLE:  if (link.sel_fall) next_state = SRAS_SHIFT;
      SRAS_SHIFT: if (link.sel_rise) next_state = SRAS_DONE;
      SRAS_DONE:  next_state = SRAS_IDLE;
      default:    next_state = SRAS_IDLE;
    endcase
  end

  // Shift register next value: load status and reply at start, shift on rising clock
  always_comb
  begin
    next_shift = shift;
    if (frame_start)
      next_shift = {i_status_events, reply_data};
    else if (bit_in)
      next_shift = {shift[FRAME_W-2:0], link.din};
  end

  // Bit count: cleared at frame start, held at forty so long frames stay valid
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    if (frame_start)
      next_bit_cnt = CNT_RST;
    else if (bit_in && !frame_ok)
      next_bit_cnt = bit_cnt + 6'h01;
  end

  // Frame state register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      state <= SRAS_IDLE;
    else
      state <= next_state;
  end

  // Datagram shift register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      shift <= SHIFT_RST;
    else
      shift <= next_shift;
  end

  // Rising clock counter
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      bit_cnt <= CNT_RST;
    else
      bit_cnt <= next_bit_cnt;
  end

  // Reply data: a write is mirrored at frame end; read data is taken while
  // o_reg_re stands, so the register file answers the address already on
  // o_reg_addr rather than one hidden inside the shift register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      reply_data <= DATA_RST;
    else if (take_wr)
      reply_data <= cmd_data;
    else if (o_reg_re)
      reply_data <= i_reg_rdata;
  end

  // Register strobes, one cycle on a complete datagram
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_reg_we <= 1'b0;
      o_reg_re <= 1'b0;
    end
    else
    begin
      o_reg_we <= take_wr;
      o_reg_re <= take_rd;
    end
  end

  // Address and write data, held until the next complete datagram
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_reg_addr  <= '0;
      o_reg_wdata <= DATA_RST;
    end
    else if (take_cmd)
    begin
      o_reg_addr  <= cmd_addr;
      o_reg_wdata <= cmd_data;
    end
  end

  // First status bit is presented one cycle after the frame loads
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      sdo_load <= 1'b0;
    else
      sdo_load <= frame_start;
  end

  // Output bit: top of shift register, updated after falling serial clock
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      sdo <= 1'b0;
    else if (sdo_load)
      sdo <= shift[FRAME_W-1];
    else if (bit_out)
      sdo <= shift[FRAME_W-1];
  end

  assign o_host_serial_out = sdo;
endmodule

// [testbench/sras_spi_slave_assertions.sv]
/* Port checker, bound to sras_spi_slave.
   Assumes the host idles its serial clock low. */
`timescale 1ns/100ps
module sras_spi_slave_chk
#(parameter int FRAME_W = 40)
(
  input wire logic        i_clk_sys, // Clock
  input wire logic        i_rst, // Reset
  input wire logic        i_host_select_n, // Select
  input wire logic        i_host_serial_clock, // SPI clock
  input wire logic        i_host_serial_in, // SPI in
  input wire logic        o_host_serial_out, // SPI out
  input wire logic [7:0]  i_status_events, // Status
  input wire logic [6:0]  o_reg_addr, // Address
  input wire logic [31:0] o_reg_wdata, // Write data
  input wire logic        o_reg_we, // Write
  input wire logic        o_reg_re, // Read
  input wire logic [31:0] i_reg_rdata // Read data
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Either strobe
  wire logic strb = o_reg_we | o_reg_re;
  sequence s_idle; i_host_select_n [*4]; endsequence
  AST_KIND: assert property (!(o_reg_we && o_reg_re)) else $error("both");
  AST_SEL: assert property (strb |-> $past(i_host_select_n, 3)) else $error("early");
  AST_ONCE: assert property (strb |=> !strb [*8]) else $error("twice");
  AST_RST: assert property ($fell(i_rst) |-> !strb && !o_host_serial_out) else $error("reset");
  AST_HOLD: assert property (s_idle |=> $stable(o_host_serial_out)) else $error("hold");
  AST_EDGE: assert property ($changed(o_host_serial_out) |-> !$past(i_host_serial_clock, 3))
    else $error("edge");
  AST_ADDR: assert property ($changed(o_reg_addr) |-> strb) else $error("addr");
  AST_DATA: assert property ($changed(o_reg_wdata) |-> strb) else $error("data");
endmodule
bind sras_spi_slave sras_spi_slave_chk #(.FRAME_W(FRAME_W)) chk_u (.*);

// [testbench/sras_host_model.sv]
/* Host master model for the SPI register access slave.
   Assumes the slave samples its pins with i_clk_sys. */
`timescale 1ns/100ps
module sras_host_model
(
  input  wire logic i_clk_sys, // Clock
  input  wire logic i_miso, // Reply
  output logic      o_sel_n = 1'b1, // Select
  output logic      o_sclk = 1'b0, // Clock out
  output logic      o_mosi = 1'b0 // Data out
);
  // One frame, top bit first; reply taken late in the high phase
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
    @(posedge i_clk_sys) o_sel_n <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_mosi <= tx[i];
      repeat (4) @(posedge i_clk_sys);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rx = {rx[62:0], i_miso};
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk_sys);
    o_sel_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (8) @(posedge i_clk_sys);
  endtask
endmodule

// [testbench/tb_spi_register_access_slave.sv]
/* Bench for the SPI register access slave.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
module tb_spi_register_access_slave;
  logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_host_select_n, i_host_serial_clock, i_host_serial_in;
  logic        o_host_serial_out, o_reg_we, o_reg_re;
  logic [7:0]  i_status_events = 8'hA5;
  logic [6:0]  o_reg_addr;
  logic [31:0] o_reg_wdata, i_reg_rdata;
  logic [63:0] rx;
  int          fails = 0, comparisons = 0, we_n = 0, re_n = 0;
  // Clock and strobe counts
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (o_reg_we === 1'b1) we_n++;
  always @(posedge i_clk_sys) if (o_reg_re === 1'b1) re_n++;
  // Register file model: answers the address on o_reg_addr at once
  assign i_reg_rdata = (o_reg_addr == 7'h21) ? 32'hFFFFFFF6 : {25'h0, o_reg_addr};
  sras_spi_slave dut_u (.*);
  sras_host_model host_u (.i_clk_sys, .i_miso(o_host_serial_out), .o_sel_n(i_host_select_n),
    .o_sclk(i_host_serial_clock), .o_mosi(i_host_serial_in));
  // Compare and count
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    comparisons++;
    if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    if (got !== exp) fails++;
  endtask
  // Counts, verdict, end of run
  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_write;
    host_u.xfer(40, 64'hA200ABCDEF, rx);
    host_u.xfer(40, 64'hA200123456, rx);
    chk("wr", {7'h22, 32'h123456, 40'hA500ABCDEF}, {o_reg_addr, o_reg_wdata, rx[39:0]});
  endtask
  task automatic t_read;
    host_u.xfer(40, 64'h21FFFFFFFF, rx);
    chk("rd_first", 40'hA500123456, rx[39:0]);
    host_u.xfer(40, 64'h2200000000, rx);
    chk("rd", {2'h2, 7'h22, 32'hFFFFFFF6}, {re_n[1:0], o_reg_addr, rx[31:0]});
  endtask
  task automatic t_chain;
    i_status_events <= 8'h81;
    host_u.xfer(8, 64'hA2, rx);
    chk("poll", {8'h81, 2'h2}, {rx[7:0], we_n[1:0]});
    host_u.xfer(48, 64'h5AA20000BEEF, rx);
    chk("chain", {8'h81, 32'h22, 8'h5A, 32'hBEEF}, {rx[47:0], o_reg_wdata});
  endtask
  // Reset, then the scenarios
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_write();
    t_read();
    t_chain();
    give_verdict();
  end
  // Cuts a hang short
  initial
  begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
